/* File: design/csm_pkg.sv */
// Package of constants and carrier types for the clock source manager
package csm_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register map and fields
	localparam logic [1:0] CSM_ADDR_CTRL = 2'h0;
	localparam logic [1:0] CSM_ADDR_STATUS = 2'h1;
	localparam logic [1:0] CSM_ADDR_MASK = 2'h2;
	localparam int CSM_UNLOCK_BIT = 7;
	localparam int CSM_EXT_SEL_BIT = 5;
	localparam int CSM_ROUTE_BIT = 4;
	localparam int CSM_MON_EN_BIT = 3;
	localparam int CSM_SLOW_STOP_BIT = 2;
	localparam int CSM_FLAG_BIT = 0;
	localparam logic [7:0] CSM_CTRL_RESET = 8'h00;
	localparam logic [1:0] CSM_MODE_SLOW = 2'h2;
	localparam logic [1:0] CSM_MODE_EXT = 2'h3;
	////////////////////////////////////////////////////////////////////////
	// Source selects, one-hot: fast RC, slow RC, external
	localparam logic [2:0] CSM_SRC_FAST = 3'h1;
	localparam logic [2:0] CSM_SRC_SLOW = 3'h2;
	localparam logic [2:0] CSM_SRC_EXT = 3'h4;
	////////////////////////////////////////////////////////////////////////
	// Fuses: zero means programmed
	localparam logic [1:0] CSM_STARTUP_SHORT = 2'h1;
	localparam logic [1:0] CSM_STARTUP_LONG = 2'h2;
	localparam logic [1:0] CSM_STARTUP_RESET = 2'h2;
	localparam logic CSM_DIV8_RESET = 1'b0;
	localparam logic CSM_FREQ_RESET = 1'b0;
	localparam logic CSM_FORCE_ON_RESET = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// Counts
	localparam int CSM_CNT_W = 14;
	localparam logic [13:0] CSM_TOUT_SHORT = 14'h0200;
	localparam logic [13:0] CSM_START_RESET = 14'h000E;
	localparam logic [13:0] CSM_START_WAKE = 14'h0006;
	localparam logic [2:0] CSM_UNLOCK_CYCLES = 3'h4;
	localparam logic [1:0] CSM_SWITCH_CYCLES = 2'h2;
	localparam logic [3:0] CSM_MON_TERMINAL = 4'hF;
	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		CSM_ST_WAIT = 5'h01,
		CSM_ST_TOUT = 5'h02,
		CSM_ST_START = 5'h04,
		CSM_ST_RUN = 5'h08,
		CSM_ST_SLEEP = 5'h10
	} csm_state_e;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} csm_bus_s;
	typedef struct packed {
		logic watchdog_osc_force_on_fuse;
		logic divide_by_eight_fuse;
		logic [1:0] startup_time_fuse;
		logic fast_osc_freq_fuse;
	} csm_fuse_s;
	typedef struct packed {
		logic [2:0] src_sel;
		logic ext_input_b_sel;
		logic slow_osc_run;
		logic cpu_clk_en;
		logic io_clk_en;
		logic flash_clk_en;
		logic timer_clk_en;
		logic slow_low_clk_en;
		logic async_irq_detect_en;
		logic div8_active;
		logic fast_osc_4mhz;
	} csm_clk_s;
endpackage

/* File: design/csm_clock_source_manager.sv */
// Clock source selection, clock fail monitor and start-up reset sequencer
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csm_clock_source_manager
	import csm_pkg::*;
#(
	parameter int TOUT_LONG_CYCLES = 8192
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire csm_bus_s bus,
	output logic [7:0] rd_data,
	input wire csm_fuse_s fuses,
	input wire logic other_reset_active,
	input wire logic slow_rc_tick,
	input wire logic presc_tick,
	input wire logic ext_clock_input_a,
	input wire logic ext_clock_input_b,
	input wire logic global_irq_enable,
	input wire logic irq_vector_ack,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic irq_req,
	output logic internal_rst_n,
	output csm_clk_s clk_ctl
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		csm_state_e st;
		logic [CSM_CNT_W-1:0] cnt;
		logic [CSM_CNT_W-1:0] target;
		logic unlock;
		logic [2:0] unlock_cnt;
		logic ext_sel;
		logic route;
		logic mon_en;
		logic slow_stop;
		logic [1:0] mode;
		logic flag;
		logic mask;
		logic [3:0] mon_cnt;
		logic ext_prev;
		logic [1:0] sw_cnt;
		csm_fuse_s fuse;
		logic [7:0] rd_data;
		logic irq_req;
		logic internal_rst_n;
		csm_clk_s clk;
	} csm_state_s;

	csm_state_s q;
	csm_state_s next_q;

	logic wr_ctrl;
	logic pure_unlock;
	logic ext_in;
	logic ext_edge;
	logic mon_active;
	logic fail;
	logic [2:0] want_src;
	logic running;
	logic [CSM_CNT_W-1:0] long_tout;

	assign long_tout = CSM_CNT_W'(TOUT_LONG_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_q = q;
		wr_ctrl = bus.wr && (bus.addr == CSM_ADDR_CTRL);
		pure_unlock = wr_ctrl && bus.wdata[CSM_UNLOCK_BIT] && (bus.wdata[6:0] == 7'h00);

		// Unlock window: a rewrite inside it neither extends nor clears it
		if (q.unlock) begin
			next_q.unlock_cnt = q.unlock_cnt - 3'h1;
			if (q.unlock_cnt == 3'h1) begin
				next_q.unlock = 1'b0;
			end
		end
		if (pure_unlock && !q.unlock) begin
			next_q.unlock = 1'b1;
			next_q.unlock_cnt = CSM_UNLOCK_CYCLES;
		end else if (wr_ctrl && q.unlock && !pure_unlock) begin
			next_q.ext_sel = bus.wdata[CSM_EXT_SEL_BIT];
			next_q.route = bus.wdata[CSM_ROUTE_BIT];
			next_q.mon_en = bus.wdata[CSM_MON_EN_BIT];
			next_q.slow_stop = bus.wdata[CSM_SLOW_STOP_BIT];
			next_q.mode = bus.wdata[1:0];
			next_q.unlock = 1'b0;
		end

		// Clock fail monitor, counted in slow ticks
		ext_in = q.ext_sel ? ext_clock_input_b : ext_clock_input_a;
		ext_edge = ext_in != q.ext_prev;
		next_q.ext_prev = ext_in;
		mon_active = q.mon_en && q.route && (q.mode == CSM_MODE_EXT) && q.clk.slow_osc_run;
		fail = 1'b0;
		if (!mon_active || ext_edge) begin
			next_q.mon_cnt = 4'h0;
		end else if (slow_rc_tick && (q.mon_cnt != CSM_MON_TERMINAL)) begin
			next_q.mon_cnt = q.mon_cnt + 4'h1;
			fail = (q.mon_cnt == CSM_MON_TERMINAL - 4'h1);
		end
		if (fail) begin
			next_q.route = 1'b0; // mode field left alone
		end

		// Flag: set wins over both kinds of clear
		if (irq_vector_ack || (bus.wr && bus.addr == CSM_ADDR_STATUS && bus.wdata[CSM_FLAG_BIT])) begin
			next_q.flag = 1'b0;
		end
		if (fail) begin
			next_q.flag = 1'b1;
		end
		if (bus.wr && bus.addr == CSM_ADDR_MASK) begin
			next_q.mask = bus.wdata[CSM_FLAG_BIT];
		end
		next_q.irq_req = next_q.mask && global_irq_enable && next_q.flag;

		// Read data stands only in the cycle after the strobe
		next_q.rd_data = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				CSM_ADDR_CTRL: next_q.rd_data = {q.unlock, 1'b0, q.ext_sel, q.route, q.mon_en,
					q.slow_stop, q.mode};
				CSM_ADDR_STATUS: next_q.rd_data = {7'h00, q.flag};
				CSM_ADDR_MASK: next_q.rd_data = {7'h00, q.mask};
				default: next_q.rd_data = 8'h00;
			endcase
		end

		// Reset and start-up sequencer
		next_q.cnt = q.cnt;
		unique case (q.st)
			CSM_ST_WAIT: begin
				// Fuses are caught while the other resets hold us
				next_q.fuse = fuses;
				next_q.cnt = '0;
				next_q.target = (fuses.startup_time_fuse == CSM_STARTUP_SHORT) ? CSM_TOUT_SHORT :
					long_tout;
				if (!other_reset_active) begin
					next_q.st = CSM_ST_TOUT;
				end
			end
			CSM_ST_TOUT: begin
				if (slow_rc_tick) begin
					next_q.cnt = q.cnt + 14'h0001;
					if (q.cnt == q.target - 14'h0001) begin
						next_q.st = CSM_ST_START;
						next_q.cnt = '0;
						next_q.target = CSM_START_RESET;
					end
				end
			end
			CSM_ST_START: begin
				if (presc_tick) begin
					next_q.cnt = q.cnt + 14'h0001;
					if (q.cnt == q.target - 14'h0001) begin
						next_q.st = CSM_ST_RUN;
					end
				end
			end
			CSM_ST_RUN: begin
				if (sleep_req) begin
					next_q.st = CSM_ST_SLEEP;
				end
			end
			CSM_ST_SLEEP: begin
				if (wake_req) begin
					next_q.st = CSM_ST_START;
					next_q.cnt = '0;
					next_q.target = CSM_START_WAKE;
				end
			end
		endcase
		if (other_reset_active) begin
			next_q.st = CSM_ST_WAIT;
		end
		next_q.internal_rst_n = (next_q.st == CSM_ST_RUN) || (next_q.st == CSM_ST_SLEEP) ||
			((next_q.st == CSM_ST_START) && (next_q.target == CSM_START_WAKE));

		// Source switch: clocks gated while the mux settles, so no runt period
		want_src = CSM_SRC_FAST;
		if (q.route && q.mode == CSM_MODE_SLOW) begin
			want_src = CSM_SRC_SLOW;
		end else if (q.route && q.mode == CSM_MODE_EXT) begin
			want_src = CSM_SRC_EXT;
		end
		if (q.sw_cnt != 2'h0) begin
			next_q.sw_cnt = q.sw_cnt - 2'h1;
			if (q.sw_cnt == 2'h1) begin
				next_q.clk.src_sel = want_src;
			end
		end else if (want_src != q.clk.src_sel) begin
			next_q.sw_cnt = CSM_SWITCH_CYCLES;
		end
		// Enables stay low one cycle past the select change
		running = (next_q.st == CSM_ST_RUN) && (next_q.sw_cnt == 2'h0) && (q.sw_cnt == 2'h0);
		next_q.clk.cpu_clk_en = running;
		next_q.clk.io_clk_en = running;
		next_q.clk.flash_clk_en = running;
		next_q.clk.timer_clk_en = running;
		next_q.clk.async_irq_detect_en = next_q.st == CSM_ST_SLEEP;
		next_q.clk.ext_input_b_sel = next_q.ext_sel;
		next_q.clk.slow_osc_run = !next_q.slow_stop ||
			!next_q.fuse.watchdog_osc_force_on_fuse;
		next_q.clk.slow_low_clk_en = next_q.clk.slow_osc_run;
		next_q.clk.div8_active = !next_q.fuse.divide_by_eight_fuse;
		next_q.clk.fast_osc_4mhz = !next_q.fuse.fast_osc_freq_fuse;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= CSM_ST_WAIT;
			q.fuse <= {CSM_FORCE_ON_RESET, CSM_DIV8_RESET, CSM_STARTUP_RESET, CSM_FREQ_RESET};
			q.clk.src_sel <= CSM_SRC_FAST;
			q.clk.slow_osc_run <= 1'b1;
			q.clk.slow_low_clk_en <= 1'b1;
			q.clk.div8_active <= 1'b1;
			q.clk.fast_osc_4mhz <= 1'b1;
			q.ext_sel <= CSM_CTRL_RESET[CSM_EXT_SEL_BIT];
		end else begin
			q <= next_q;
		end
	end

	assign rd_data = q.rd_data;
	assign irq_req = q.irq_req;
	assign internal_rst_n = q.internal_rst_n;
	assign clk_ctl = q.clk;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_unlock_expire;
		@(posedge clock) disable iff (!rst_n) $rose(q.unlock) |-> ##[1:4] !q.unlock;
	endproperty
	a_unlock_expire: assert property (p_unlock_expire)
		else $error("unlock stayed past four cycles");

	property p_locked_write;
		@(posedge clock) disable iff (!rst_n)
			(wr_ctrl && !q.unlock && !pure_unlock && !fail) |=> $stable(q.mode) && $stable(q.route);
	endproperty
	a_locked_write: assert property (p_locked_write)
		else $error("locked control field changed");

	property p_stop_osc;
		@(posedge clock) disable iff (!rst_n)
			(q.slow_stop && q.fuse.watchdog_osc_force_on_fuse) |-> !clk_ctl.slow_osc_run;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("slow oscillator not stopped");

	property p_force_on;
		@(posedge clock) disable iff (!rst_n) !q.fuse.watchdog_osc_force_on_fuse |-> clk_ctl.slow_osc_run;
	endproperty
	a_force_on: assert property (p_force_on) else $error("forced oscillator stopped");

	property p_fail_route;
		@(posedge clock) disable iff (!rst_n) fail |=> q.flag && !q.route && $stable(q.mode);
	endproperty
	a_fail_route: assert property (p_fail_route) else $error("failure handling wrong");

	property p_irq;
		@(posedge clock) disable iff (!rst_n) irq_req |-> q.mask && q.flag && $past(global_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");

	property p_rsvd_read;
		@(posedge clock) disable iff (!rst_n)
			(bus.rd && bus.addr != CSM_ADDR_CTRL) |=> rd_data[7:1] == 7'h00;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero");

	property p_ack_clear;
		@(posedge clock) disable iff (!rst_n) (irq_vector_ack && !fail) |=> !q.flag;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared by vector");

	property p_w1c_clear;
		@(posedge clock) disable iff (!rst_n)
			(bus.wr && bus.addr == CSM_ADDR_STATUS && bus.wdata[CSM_FLAG_BIT] && !fail) |=> !q.flag;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by write");

	property p_tout_hold;
		@(posedge clock) disable iff (!rst_n) (q.st == CSM_ST_TOUT) |-> !internal_rst_n;
	endproperty
	a_tout_hold: assert property (p_tout_hold) else $error("time-out reset released");

	property p_start_hold;
		@(posedge clock) disable iff (!rst_n)
			(q.st == CSM_ST_START && q.target == CSM_START_RESET) |-> !internal_rst_n;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("reset released early");

	property p_fast_route;
		@(posedge clock) disable iff (!rst_n) (!q.route)[*4] |-> clk_ctl.src_sel == CSM_SRC_FAST;
	endproperty
	a_fast_route: assert property (p_fast_route) else $error("fast RC not selected");

	property p_switch_gap;
		@(posedge clock) disable iff (!rst_n)
			$changed(clk_ctl.src_sel) |-> !clk_ctl.cpu_clk_en && !$past(clk_ctl.cpu_clk_en);
	endproperty
	a_switch_gap: assert property (p_switch_gap)
		else $error("source switched while clocked");

	property p_wake;
		@(posedge clock) disable iff (!rst_n)
			(q.st == CSM_ST_SLEEP && wake_req && !other_reset_active) |=> internal_rst_n &&
				q.target == CSM_START_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake applied reset time-out");

	c_fail: cover property (@(posedge clock) disable iff (!rst_n) fail);
	c_wake: cover property (@(posedge clock) disable iff (!rst_n)
		q.st == CSM_ST_SLEEP ##1 q.st == CSM_ST_START);
	c_ext: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(clk_ctl.src_sel == CSM_SRC_EXT));
	c_slow: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(clk_ctl.src_sel == CSM_SRC_SLOW));
	c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq_req));

endmodule // csm_clock_source_manager
`default_nettype wire

/* File: sim/test_clock_source_manager.sv */
// Self-checking bench for the clock source manager
`timescale 1ns/1ps
`default_nettype none
module test_clock_source_manager
	import csm_pkg::*;
;
	logic clock;
	logic rst_n;
	csm_bus_s bus;
	logic [7:0] rd_data;
	csm_fuse_s fuses;
	logic oth, slow_tick, presc, ext_a, ext_b, gie, ack, slp, wk;
	logic irq_req, irst_n, rd_pend;
	csm_clk_s clk_ctl;
	int err_total, checked, seed;
	logic [7:0] expq[$];
	logic [7:0] cur, d;
	logic [2:0] src_exp [4];
	csm_clock_source_manager #(.TOUT_LONG_CYCLES(20)) uut (
		.clock(clock), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .fuses(fuses),
		.other_reset_active(oth), .slow_rc_tick(slow_tick), .presc_tick(presc),
		.ext_clock_input_a(ext_a), .ext_clock_input_b(ext_b), .global_irq_enable(gie),
		.irq_vector_ack(ack), .sleep_req(slp), .wake_req(wk), .irq_req(irq_req),
		.internal_rst_n(irst_n), .clk_ctl(clk_ctl)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Two cycles per access, so a strobe is never raised in the step that lowers it
	task automatic op(input logic w, input logic [1:0] a, input logic [7:0] v);
		@(posedge clock);
		bus <= '{addr: a, wdata: v, wr: w, rd: !w};
		@(posedge clock);
		bus <= '0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		expq.push_back(e);
		op(1'b0, a, 8'h00);
	endtask
	task automatic set_ctl(input logic [7:0] v);
		op(1'b1, CSM_ADDR_CTRL, 8'h80);
		op(1'b1, CSM_ADDR_CTRL, v);
		cur = v;
	endtask
	// Idle gap after each tick leaves room for the ext_prev edge detector
	task automatic sticks(input int n, input logic tog);
		repeat (n) begin
			@(posedge clock);
			slow_tick <= 1'b1;
			@(posedge clock);
			slow_tick <= 1'b0;
			if (tog) ext_a <= !ext_a;
			cyc(4);
		end
	endtask
	task automatic pticks(input int n);
		repeat (n) begin
			@(posedge clock);
			presc <= 1'b1;
			@(posedge clock);
			presc <= 1'b0;
		end
	endtask
	task automatic startup(input logic [1:0] code, input int n);
		@(posedge clock);
		oth <= 1'b1;
		fuses.startup_time_fuse <= code;
		cyc(3);
		oth <= 1'b0;
		cyc(3);
		sticks(n - 1, 1'b0);
		chk(irst_n, 1'b0);
		sticks(1, 1'b0);
		pticks(13);
		chk(irst_n, 1'b0);
		pticks(1);
		cyc(3);
		chk(irst_n, 1'b1);
		$display("start-up code %h done", code);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		rd_pend <= bus.rd;
	end
	// Read data stand only in the cycle after the strobe
	always @(negedge clock) begin
		if (rd_pend === 1'b1) begin
			chk(rd_data, expq.size() ? expq.pop_front() : 8'hXX);
		end
	end
	initial begin
		clock = 1'b0;
		forever #10 clock = !clock;
	end
	// Whole run is a few thousand cycles
	initial begin
		#400000;
		err_total++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h9acd;
		rst_n = 1'b0;
		bus = '0;
		fuses = '{CSM_FORCE_ON_RESET, CSM_DIV8_RESET, CSM_STARTUP_RESET, CSM_FREQ_RESET};
		{oth, slow_tick, presc, ext_a, ext_b, gie, ack, slp, wk} = 9'h000;
		src_exp = '{CSM_SRC_FAST, CSM_SRC_FAST, CSM_SRC_SLOW, CSM_SRC_EXT};
		cur = 8'h00;
		cyc(2);
		chk(irst_n, 1'b0);
		chk(clk_ctl.src_sel, CSM_SRC_FAST);
		chk({clk_ctl.div8_active, clk_ctl.fast_osc_4mhz}, 2'h3);
		cyc(2);
		rst_n <= 1'b1;
		$display("reset test done");
		startup(2'h1, 512);
		startup(2'h0, 20);
		startup(2'h3, 20);
		startup(2'h2, 20);
		chk({clk_ctl.cpu_clk_en, clk_ctl.io_clk_en, clk_ctl.flash_clk_en}, 3'h7);
		chk(clk_ctl.timer_clk_en, 1'b1);
		@(posedge clock);
		slp <= 1'b1;
		@(posedge clock);
		slp <= 1'b0;
		cyc(2);
		chk({clk_ctl.cpu_clk_en, clk_ctl.io_clk_en, clk_ctl.async_irq_detect_en}, 3'h1);
		chk(clk_ctl.slow_low_clk_en, 1'b1);
		@(posedge clock);
		wk <= 1'b1;
		@(posedge clock);
		wk <= 1'b0;
		pticks(5);
		chk(clk_ctl.cpu_clk_en, 1'b0);
		pticks(1);
		cyc(3);
		chk({clk_ctl.cpu_clk_en, irst_n}, 2'h3);
		$display("sleep test done");
		op(1'b1, CSM_ADDR_CTRL, 8'h13);
		rd(CSM_ADDR_CTRL, 8'h00);
		op(1'b1, CSM_ADDR_CTRL, 8'h80);
		cyc(5);
		op(1'b1, CSM_ADDR_CTRL, 8'h02);
		rd(CSM_ADDR_CTRL, 8'h00);
		op(1'b1, CSM_ADDR_CTRL, 8'h81);
		op(1'b1, CSM_ADDR_CTRL, 8'h02);
		rd(CSM_ADDR_CTRL, 8'h00);
		op(1'b1, CSM_ADDR_CTRL, 8'h80);
		rd(CSM_ADDR_CTRL, 8'h80);
		cyc(4);
		rd(CSM_ADDR_CTRL, 8'h00);
		repeat (4) begin
			d = 8'($random(seed));
			op(1'b1, CSM_ADDR_MASK, d);
			rd(CSM_ADDR_MASK, {7'h00, d[0]});
			op(1'b1, 2'h3, d);
			rd(2'h3, 8'h00);
		end
		rd(CSM_ADDR_STATUS, 8'h00);
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			set_ctl(cur & 8'hEF);
			set_ctl(8'(m));
			cyc(6);
			chk(clk_ctl.src_sel, CSM_SRC_FAST);
			set_ctl(8'h10 | 8'(m));
			cyc(6);
			chk(clk_ctl.src_sel, src_exp[m]);
		end
		$display("mode test done");
		sticks(16, 1'b0);
		rd(CSM_ADDR_STATUS, 8'h00);
		set_ctl(8'h1B);
		sticks(3, 1'b1);
		sticks(14, 1'b0);
		rd(CSM_ADDR_STATUS, 8'h00);
		sticks(1, 1'b0);
		cyc(3);
		rd(CSM_ADDR_STATUS, 8'h01);
		rd(CSM_ADDR_CTRL, 8'h0B);
		chk(clk_ctl.src_sel, CSM_SRC_FAST);
		$display("monitor test done");
		op(1'b1, CSM_ADDR_MASK, 8'h01);
		gie <= 1'b1;
		cyc(3);
		chk(irq_req, 1'b1);
		gie <= 1'b0;
		cyc(3);
		chk(irq_req, 1'b0);
		gie <= 1'b1;
		op(1'b1, CSM_ADDR_MASK, 8'h00);
		cyc(3);
		chk(irq_req, 1'b0);
		op(1'b1, CSM_ADDR_MASK, 8'h01);
		op(1'b1, CSM_ADDR_STATUS, 8'h01);
		cyc(3);
		chk(irq_req, 1'b0);
		rd(CSM_ADDR_STATUS, 8'h00);
		set_ctl(8'h1B);
		sticks(2, 1'b1);
		sticks(15, 1'b0);
		cyc(3);
		chk(irq_req, 1'b1);
		ack <= 1'b1;
		@(posedge clock);
		ack <= 1'b0;
		cyc(3);
		rd(CSM_ADDR_STATUS, 8'h00);
		$display("interrupt test done");
		// Second input selected while only the first one toggles
		set_ctl(8'h2B);
		set_ctl(8'h3B);
		cyc(6);
		chk({clk_ctl.ext_input_b_sel, clk_ctl.src_sel}, 4'hC);
		sticks(15, 1'b1);
		rd(CSM_ADDR_STATUS, 8'h01);
		rd(CSM_ADDR_CTRL, 8'h2B);
		op(1'b1, CSM_ADDR_STATUS, 8'h01);
		rd(CSM_ADDR_STATUS, 8'h00);
		$display("second input test done");
		set_ctl(8'h04);
		cyc(3);
		chk({clk_ctl.slow_osc_run, clk_ctl.slow_low_clk_en}, 2'h0);
		set_ctl(8'h00);
		cyc(3);
		chk({clk_ctl.slow_osc_run, clk_ctl.slow_low_clk_en}, 2'h3);
		// Fuses are only sampled while the sequencer waits
		fuses.watchdog_osc_force_on_fuse <= 1'b0;
		oth <= 1'b1;
		cyc(3);
		set_ctl(8'h04);
		cyc(3);
		chk(clk_ctl.slow_osc_run, 1'b1);
		$display("slow oscillator test done");
		conclude();
	end
endmodule // test_clock_source_manager
`default_nettype wire
